// [hw/adf_params.svh]
// Offsets, field positions, reset values and timing counts of the decoder feed block
`ifndef ADF_PARAMS_SVH
`define ADF_PARAMS_SVH

// Register byte offsets
`define ADF_OFS_CTRL      5'h00
`define ADF_OFS_STAT      5'h04
`define ADF_OFS_STATB     5'h08
`define ADF_OFS_DATA      5'h0c
`define ADF_OFS_CLKDIV    5'h10

// Control register fields
`define ADF_CTRL_EN       0
`define ADF_CTRL_IRQEN    1

// Primary status fields
`define ADF_STAT_REQ      0
`define ADF_STAT_VER      1
`define ADF_STAT_FS_LO    2
`define ADF_STAT_FS_HI    3
`define ADF_STAT_BADFMT   4

// Secondary status fields
`define ADF_STATB_FREQ    0
`define ADF_STATB_BREQ    1

// Divider field width and reset value
`define ADF_DIV_W         5
`define ADF_DIV_RST       5'h01

// Stream sizes and timing counts
`define ADF_FILL_BYTES    1024
`define ADF_FRAME_BYTES   417
`define ADF_DECODE_TICKS  64

// Frame header layout: sync byte, version bit, layer bits, rate bits
`define ADF_SYNC_BYTE     8'hff
`define ADF_HDR_VER_BIT   3
`define ADF_HDR_LAYER_HI  2
`define ADF_HDR_LAYER_LO  1
`define ADF_LAYER3_CODE   2'h1
`define ADF_HDR_FS_HI     3
`define ADF_HDR_FS_LO     2
`define ADF_FS_RESERVED   2'h3

`endif

// [hw/adf_pkg.sv]
// Types shared by the decoder feed block
package adf_pkg;

    // Decoder sequencer states
    typedef enum logic [1:0] {
        DecIdle,
        DecHeader,
        DecRun,
        DecRetire
    } adf_dec_e;

    // Frame information seen by software
    typedef struct packed {
        logic       badFormat;     // Last header was not a supported stream
        logic [1:0] sampleRateCode;
        logic       streamVersionBit;
    } adf_frame_s;

    // Request and handshake flags
    typedef struct packed {
        logic byteToggleFlag;
        logic frameRequestFlag;
        logic inputRequestFlag;
    } adf_req_s;

endpackage

// [hw/adf_feed_ctrl.sv]
// Decoder input feed control: Avalon slave, input buffer, request flags, clock divider
//
// Function
// - Decode only once full frame is buffered
// - Need for data sets input and frame request flags
// - Interrupt from request flag only when enabled
// - Frame request flag high while data wanted; code clears it when the last requested byte and a frame retire share a cycle
// - Byte toggle flag inverts per accepted data byte
// - First request after enable asks 1024 bytes
// - Reading primary status clears request flag
// - Decoder clock is PLL clock divided
// - Accept MPEG I layer-3 at 48/44.1/32
// - Accept MPEG II layer-3 at 24/22.05/16
// - Decode frames fast enough for real time
// - Status reports version bit and rate code
`timescale 1ns/1ns
`include "adf_params.svh"

module adf_feed_ctrl
    import adf_pkg::*;
#(
    parameter int unsigned BUF_BYTES    = `ADF_FILL_BYTES,   // Input buffer size
    parameter int unsigned FRAME_BYTES  = `ADF_FRAME_BYTES,  // Bytes per frame
    parameter int unsigned DECODE_TICKS = `ADF_DECODE_TICKS  // Decoder ticks per frame
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Decoder side
    output logic             decoderIrq,
    output logic             decClk,
    output logic             frameDone,
    output logic             frameAccepted
);

    localparam int PTR_W = $clog2(BUF_BYTES);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] BUF_FULL  = CNT_W'(BUF_BYTES);
    localparam logic [CNT_W-1:0] FRAME_LEN = CNT_W'(FRAME_BYTES);
    localparam logic [15:0]      RUN_LAST  = 16'(DECODE_TICKS - 1);

    // Bus handshake
    logic              ackQ;           // Second cycle of an access
    logic              rdAck;          // Read completes this edge
    logic              wrAck;          // Write completes this edge
    logic [31:0]       rdDataQ;        // Registered read data
    // Software registers
    logic              enableQ;        // Decoder enable
    logic              irqEnableQ;     // Request interrupt enable
    logic [4:0]        divisorQ;       // Decoder clock divisor
    adf_req_s          reqQ;           // Handshake flags
    adf_frame_s        frameQ;         // Frame information
    logic              enableDlyQ;     // Enable one cycle late
    // Buffer
    logic [7:0]        bufMem [BUF_BYTES];
    logic [PTR_W-1:0]  wrPtrQ;
    logic [PTR_W-1:0]  rdPtrQ;
    logic [CNT_W-1:0]  countQ;
    logic [CNT_W-1:0]  countD;
    logic [CNT_W-1:0]  remainQ;        // Bytes still requested
    logic              byteIn;         // Data write accepted
    logic              startFill;      // Enable just rose
    // Decoder sequencer
    adf_dec_e          decQ;
    logic [15:0]       runCntQ;
    logic              retire;         // Frame leaves the buffer
    logic              newRequest;     // A fresh request begins
    // Clock divider
    logic [4:0]        divCntQ;
    logic              decTick;
    logic [7:0]        hdrB0;
    logic [7:0]        hdrB1;
    logic [7:0]        hdrB2;

    // Waitrequest held for one cycle on every access
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ackQ <= 1'b0;
        else
            ackQ <= (avs_read | avs_write) & ~ackQ;
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ackQ;
    assign rdAck = avs_read & ackQ;
    assign wrAck = avs_write & ackQ;
    assign avs_readdata = rdDataQ;

    // Read data sampled in the waiting cycle, stands through the ack edge
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdDataQ <= 32'h0;
        else if (avs_read & ~ackQ)
        begin
            rdDataQ <= 32'h0;
            case (avs_address)
                `ADF_OFS_CTRL:
                begin
                    rdDataQ[`ADF_CTRL_EN]    <= enableQ;
                    rdDataQ[`ADF_CTRL_IRQEN] <= irqEnableQ;
                end
                `ADF_OFS_STAT:
                begin
                    rdDataQ[`ADF_STAT_REQ] <= reqQ.inputRequestFlag;
                    rdDataQ[`ADF_STAT_VER] <= frameQ.streamVersionBit;
                    rdDataQ[`ADF_STAT_FS_HI:`ADF_STAT_FS_LO] <= frameQ.sampleRateCode;
                    rdDataQ[`ADF_STAT_BADFMT] <= frameQ.badFormat;
                end
                `ADF_OFS_STATB:
                begin
                    rdDataQ[`ADF_STATB_FREQ] <= reqQ.frameRequestFlag;
                    rdDataQ[`ADF_STATB_BREQ] <= reqQ.byteToggleFlag;
                end
                `ADF_OFS_CLKDIV:
                    rdDataQ[`ADF_DIV_W-1:0] <= divisorQ;
                default:
                    rdDataQ <= 32'h0;            // Data port and holes read zero
            endcase
        end
    end

    // Control and divider registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enableQ    <= 1'b0;
            irqEnableQ <= 1'b0;
            divisorQ   <= `ADF_DIV_RST;
        end
        else if (wrAck && avs_address == `ADF_OFS_CTRL)
        begin
            enableQ    <= avs_writedata[`ADF_CTRL_EN];
            irqEnableQ <= avs_writedata[`ADF_CTRL_IRQEN];
        end
        else if (wrAck && avs_address == `ADF_OFS_CLKDIV)
            divisorQ <= avs_writedata[`ADF_DIV_W-1:0];
    end

    // Enable edge starts the initial fill
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            enableDlyQ <= 1'b0;
        else
            enableDlyQ <= enableQ;
    end

    assign startFill = enableQ & ~enableDlyQ;

    // Byte is stored only while enabled and the buffer has room
    assign byteIn = wrAck && avs_address == `ADF_OFS_DATA && enableQ && countQ != BUF_FULL;

    // Buffer write in arrival order; no reset needed on the array
    always_ff @(posedge mclk)
    begin
        if (byteIn)
            bufMem[wrPtrQ] <= avs_writedata[7:0];
    end

    // Fill level bookkeeping
    always_comb
    begin
        countD = countQ;
        if (byteIn)
            countD = countD + CNT_W'(1);
        if (retire)
            countD = countD - FRAME_LEN;
    end

    // Pointers and fill level, flushed when disabled
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
        end
        else if (!enableQ)
        begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
        end
        else
        begin
            if (byteIn)
                wrPtrQ <= wrPtrQ + PTR_W'(1);
            if (retire)
                rdPtrQ <= rdPtrQ + PTR_W'(FRAME_BYTES);
            countQ <= countD;
        end
    end

    // Outstanding request size; first one fills the whole buffer
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            remainQ <= '0;
        else if (!enableQ)
            remainQ <= '0;
        else if (startFill)
            remainQ <= BUF_FULL;
        else if (retire)
            remainQ <= remainQ + FRAME_LEN - CNT_W'(byteIn);  // Refill freed space
        else if (byteIn && remainQ != '0)
            remainQ <= remainQ - CNT_W'(1);
    end

    assign newRequest = startFill | (retire & remainQ == '0);

    // Request flags; a new request wins over a status read
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            reqQ <= '0;
        else
        begin
            if (newRequest)
                reqQ.inputRequestFlag <= 1'b1;
            else if (rdAck && avs_address == `ADF_OFS_STAT)
                reqQ.inputRequestFlag <= 1'b0;
            if (newRequest)
                reqQ.frameRequestFlag <= 1'b1;
            else if (!enableQ || (byteIn && remainQ == CNT_W'(1)))
                reqQ.frameRequestFlag <= 1'b0;
            if (byteIn)
                reqQ.byteToggleFlag <= ~reqQ.byteToggleFlag;
        end
    end

    // Interrupt gated by its enable
    assign decoderIrq = reqQ.inputRequestFlag & irqEnableQ;

    // Decoder clock: one tick per divisor cycles of the PLL clock
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divCntQ <= '0;
            decClk  <= 1'b0;
        end
        else
        begin
            divCntQ <= decTick ? 5'h0 : divCntQ + 5'h1;
            decClk  <= (divCntQ < (divisorQ >> 1));
        end
    end

    // Divisor of zero or one runs the decoder at the full rate
    assign decTick = (divCntQ + 5'h1 >= divisorQ);

    // Header bytes at the head of the buffer
    assign hdrB0 = bufMem[rdPtrQ];
    assign hdrB1 = bufMem[rdPtrQ + PTR_W'(1)];
    assign hdrB2 = bufMem[rdPtrQ + PTR_W'(2)];

    assign retire = (decQ == DecRetire);

    // Frame sequencer; run phase counts decoder ticks
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            decQ          <= DecIdle;
            runCntQ       <= '0;
            frameQ        <= '0;
            frameDone     <= 1'b0;
            frameAccepted <= 1'b0;
        end
        else if (!enableQ)
        begin
            decQ      <= DecIdle;
            frameDone <= 1'b0;
        end
        else
        begin
            frameDone <= 1'b0;
            case (decQ)
                DecIdle:
                    if (countQ >= FRAME_LEN)
                        decQ <= DecHeader;
                DecHeader:
                begin
                    // Version and rate straight from the header
                    frameQ.streamVersionBit <= hdrB1[`ADF_HDR_VER_BIT];
                    frameQ.sampleRateCode   <= hdrB2[`ADF_HDR_FS_HI:`ADF_HDR_FS_LO];
                    // Layer 3 with any defined rate of either version
                    if (hdrB0 == `ADF_SYNC_BYTE &&
                        hdrB1[`ADF_HDR_LAYER_HI:`ADF_HDR_LAYER_LO] == `ADF_LAYER3_CODE &&
                        hdrB2[`ADF_HDR_FS_HI:`ADF_HDR_FS_LO] != `ADF_FS_RESERVED)
                    begin
                        frameQ.badFormat <= 1'b0;
                        frameAccepted    <= 1'b1;
                        runCntQ          <= '0;
                        decQ             <= DecRun;
                    end
                    else
                    begin
                        frameQ.badFormat <= 1'b1;            // Unsupported frame skipped
                        frameAccepted    <= 1'b0;
                        decQ             <= DecRetire;
                    end
                end
                DecRun:
                    // Fixed tick budget per frame keeps pace with playback
                    if (decTick)
                    begin
                        if (runCntQ == RUN_LAST)
                            decQ <= DecRetire;
                        else
                            runCntQ <= runCntQ + 16'h1;
                    end
                DecRetire:
                begin
                    frameDone <= 1'b1;
                    decQ      <= DecIdle;
                end
                default:
                    decQ <= DecIdle;
            endcase
        end
    end

endmodule

// [tb/adf_feed_ctrl_monitor.sv]
// Bus handshake and request flag assertions for the decoder feed block
`timescale 1ns/1ns
`include "adf_params.svh"
module adf_feed_ctrl_monitor
    import adf_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    // Decoder side
    input  wire logic        decoderIrq,
    input  wire logic        decClk,
    input  wire logic        frameDone,
    input  wire logic        frameAccepted
);
    logic busReq;  // Any access pending
    logic irqEnQ;  // Shadow of the interrupt enable bit

    assign busReq = avs_read || avs_write;

    // Shadow updates only on the completing edge, like the real register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            irqEnQ <= 1'b0;
        else if (avs_write && !avs_waitrequest && avs_address == `ADF_OFS_CTRL)
            irqEnQ <= avs_writedata[`ADF_CTRL_IRQEN];
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_wait_first: assert property ($rose(busReq) |-> avs_waitrequest)
        else $error("new access completed without a wait cycle");
    chk_wait_once: assert property (busReq && avs_waitrequest |=> !avs_waitrequest)
        else $error("access held more than one wait cycle");
    chk_idle_quiet: assert property (!busReq |-> !avs_waitrequest)
        else $error("waitrequest high with no access");
    chk_irq_masked: assert property (decoderIrq |-> irqEnQ)
        else $error("interrupt raised while disabled");
    chk_req_cleared: assert property (avs_read && !avs_waitrequest
        && avs_address == `ADF_OFS_STAT |=> !decoderIrq || frameDone)
        else $error("request flag survived status read");
    chk_zero_read: assert property (avs_read && !avs_waitrequest
        && !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h10}) |-> avs_readdata == 32'h0)
        else $error("data port or unmapped read not zero");
    chk_done_single: assert property (frameDone |=> !frameDone)
        else $error("frame retire pulse longer than one cycle");
    chk_reset_quiet: assert property ($rose(rst_n) |-> !decoderIrq && !frameDone
        && !frameAccepted && !decClk)
        else $error("outputs not idle after reset");
    chk_ctrl_readback: assert property (avs_read && !avs_waitrequest
        && avs_address == `ADF_OFS_CTRL |-> avs_readdata[1] == irqEnQ)
        else $error("interrupt enable reads back wrong");
endmodule

// [tb/adf_cpu_model.sv]
// Processor-side bus master that feeds the decoder through its registers
`timescale 1ns/1ns
module adf_cpu_model
    import adf_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Avalon-MM master
    output logic      [4:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    // Idle bus from time zero
    initial
    begin
        {address, read, write, writedata} = '0;
    end

    // One access; held until waitrequest low, one idle cycle before the next
    task automatic xfer(input logic isWr, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        @(posedge mclk);
        address   <= a;
        writedata <= d;
        read      <= ~isWr;
        write     <= isWr;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 40);
        q  = readdata;
        ok = (waitrequest === 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
    endtask
endmodule

// [tb/adf_feed_ctrl_bench.sv]
// Self-checking bench for the decoder feed block
`timescale 1ns/1ns
`include "adf_params.svh"
module adf_feed_ctrl_bench
    import adf_pkg::*;
;
    localparam int DIV = 31;  // Slow decoder clock keeps two frames buffered
    logic        mclk;
    logic        rst_n;
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        decoderIrq;
    logic        decClk;
    logic        frameDone;
    logic        frameAccepted;
    logic [31:0] q;
    int          errTotal = 0;
    int          cmpCount = 0;
    int          doneCount = 0;
    int          cyc = 0;
    int          lastDone = 0;
    int          prevDone = 0;
    int          span = 0;      // Measured cycle span

    adf_feed_ctrl #(.BUF_BYTES(16), .FRAME_BYTES(8), .DECODE_TICKS(4)) adf_feed_ctrl_inst (
        .mclk(mclk), .rst_n(rst_n), .avs_address(address), .avs_read(read),
        .avs_write(write), .avs_writedata(writedata), .avs_readdata(readdata),
        .avs_waitrequest(waitrequest), .decoderIrq(decoderIrq), .decClk(decClk),
        .frameDone(frameDone), .frameAccepted(frameAccepted));
    adf_cpu_model adf_cpu_model_inst (
        .mclk(mclk), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Retire pulse log; non-blocking so waiters never race it
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (frameDone === 1'b1)
        begin
            doneCount <= doneCount + 1;
            lastDone  <= cyc;
            prevDone  <= lastDone;
        end
    end

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bus access; a hung handshake ends the run
    task automatic bus(input logic isWr, input logic [4:0] a, input logic [31:0] d);
        logic ok;
        adf_cpu_model_inst.xfer(isWr, a, d, q, ok);
        if (ok !== 1'b1)
        begin
            errTotal++;
            $display("ERROR bus answer expected 1 seen %b", ok);
            conclude();
        end
    endtask

    task automatic rdchk(input string what, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, q, exp);
    endtask

    // Frame bytes: sync, version and layer, rate, then filler
    function automatic logic [7:0] fb(input logic [7:0] b1, input logic [7:0] b2, input int i);
        return (i == 0) ? 8'hff : (i == 1) ? b1 : (i == 2) ? b2 : 8'h30 + 8'(i);
    endfunction

    task automatic send(input logic [7:0] b1, input logic [7:0] b2, input int lo, input int hi);
        for (int i = lo; i <= hi; i++)
            bus(1'b1, `ADF_OFS_DATA, {24'h0, fb(b1, b2, i)});
    endtask

    // Bounded wait for the next retire pulse
    task automatic waitDone();
        int n;
        int start;
        start = doneCount;
        n = 0;
        while (doneCount == start && n < 400)
        begin
            @(posedge mclk);
            n++;
        end
        if (doneCount == start)
        begin
            errTotal++;
            $display("ERROR frame retire expected pulse seen none");
            conclude();
        end
    endtask

    // Decoder clock period in mclk cycles between two observed rising levels
    task automatic clkPeriod(output int p);
        int n;
        n = 0;
        p = 0;
        while (decClk !== 1'b0 && n < 100)
        begin
            @(posedge mclk);
            n++;
        end
        while (decClk !== 1'b1 && n < 100)
        begin
            @(posedge mclk);
            n++;
        end
        while (decClk !== 1'b0 && p < 100)
        begin
            @(posedge mclk);
            p++;
        end
        while (decClk !== 1'b1 && p < 100)
        begin
            @(posedge mclk);
            p++;
        end
    endtask

    initial
    begin
        rst_n = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset values and quiet ports
        rdchk("control", `ADF_OFS_CTRL, 32'h0);
        rdchk("status", `ADF_OFS_STAT, 32'h0);
        rdchk("status b", `ADF_OFS_STATB, 32'h0);
        rdchk("divisor", `ADF_OFS_CLKDIV, {27'h0, `ADF_DIV_RST});
        rdchk("data port", `ADF_OFS_DATA, 32'h0);
        rdchk("unmapped", 5'h14, 32'h0);
        bus(1'b1, `ADF_OFS_DATA, 32'h55); // Refused while disabled
        rdchk("toggle when disabled", `ADF_OFS_STATB, 32'h0);
        $display("Test reset values done");
        // Enable raises the first request and the interrupt
        bus(1'b1, `ADF_OFS_CLKDIV, DIV);
        bus(1'b1, `ADF_OFS_CTRL, 32'h3);
        repeat (3) @(posedge mclk);
        chk("interrupt", 32'(decoderIrq), 32'h1);
        rdchk("request", `ADF_OFS_STAT, 32'h1);
        @(posedge mclk);
        chk("interrupt after read", 32'(decoderIrq), 32'h0);
        rdchk("request cleared", `ADF_OFS_STAT, 32'h0);
        rdchk("frame request", `ADF_OFS_STATB, 32'h1);
        $display("Test request done");
        // Fill: two frames, 16 bytes in all, then one refused byte
        send(8'h0a, 8'h04, 0, 0);
        rdchk("toggle one byte", `ADF_OFS_STATB, 32'h3);
        send(8'h0a, 8'h04, 1, 7);
        send(8'h02, 8'h08, 0, 7);
        rdchk("fill complete", `ADF_OFS_STATB, 32'h0);
        bus(1'b1, `ADF_OFS_DATA, 32'haa);
        rdchk("full refused", `ADF_OFS_STATB, 32'h0);
        rdchk("version one rate", `ADF_OFS_STAT, 32'h6);
        chk("accepted", 32'(frameAccepted), 32'h1);
        chk("no early retire", doneCount, 0);
        $display("Test fill done");
        // Retire of first frame requests more; second frame decodes next
        waitDone();
        repeat (4) @(posedge mclk);
        rdchk("version two rate", `ADF_OFS_STAT, 32'h9);
        rdchk("frame request again", `ADF_OFS_STATB, 32'h1);
        waitDone();
        span = lastDone - prevDone;
        chk("decode span", 32'(span >= 4 * DIV && span <= 160), 32'h1);
        $display("Test decode done");
        // Re-enable with interrupt masked: fresh fill request, bad header held until whole
        bus(1'b1, `ADF_OFS_CTRL, 32'h0);
        bus(1'b1, `ADF_OFS_CTRL, 32'h1);
        rdchk("control readback", `ADF_OFS_CTRL, 32'h1);
        rdchk("refill request", `ADF_OFS_STATB, 32'h1);
        send(8'h0a, 8'h0c, 0, 6);
        repeat (60) @(posedge mclk);
        chk("partial frame held", doneCount, 2);
        send(8'h0a, 8'h0c, 7, 7);
        waitDone();
        chk("bad rejected", 32'(frameAccepted), 32'h0);
        chk("masked interrupt", 32'(decoderIrq), 32'h0);
        rdchk("bad format", `ADF_OFS_STAT, 32'h1f);
        rdchk("bad status cleared", `ADF_OFS_STAT, 32'h1e);
        $display("Test bad frame done");
        // Decoder clock period follows the divisor
        clkPeriod(span);
        chk("clock period", span, DIV);
        bus(1'b1, `ADF_OFS_CLKDIV, 32'h4);
        rdchk("divisor set", `ADF_OFS_CLKDIV, 32'h4);
        clkPeriod(span);
        chk("fast clock period", span, 4);
        $display("Test decoder clock done");
        conclude();
    end
endmodule

bind adf_feed_ctrl adf_feed_ctrl_monitor adf_feed_ctrl_monitor_inst (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .decoderIrq(decoderIrq), .decClk(decClk),
    .frameDone(frameDone), .frameAccepted(frameAccepted));
